//--- ptm_defines.svh
// How it works
// RULE1 - each pair runs as one 32-bit timer or two separate 16-bit timers
// RULE2 - pair modes: two 16-bit timers, one 32-bit timer, one 32-bit counter
// RULE3 - no asynchronous counter mode; external pulses are always synchronised first
// RULE4 - gated counting, selectable prescaler, counting continues in idle and sleep; the code stops it in idle when idle_stop is set and has no sleep input
// RULE5 - 32-bit use raises an interrupt when 32-bit count matches 32-bit period
// RULE6 - only pair a timers serve as capture and compare time base
// RULE7 - converter trigger comes from 32-bit pairs or high timers, never low timers
// RULE8 - each 16-bit timer counts internal clock or synchronised external pulses
// RULE9 - in 32-bit use the low timer is the low word, high timer the high word
// RULE10 - in 32-bit use only the low timer control is used, high ignored
// RULE11 - in 32-bit use the low timer clock and gate inputs drive the pair
// RULE12 - in 32-bit use the period match flags on the high timer only
// RULE13 - each of the four timers can request a dma transfer
// RULE14 - software picks mode and features through each timer control register
// RULE15 - after a period match the next counting edge returns the count to zero
`ifndef PTM_DEFINES_SVH
`define PTM_DEFINES_SVH
`define PTM_GRP_CTRL   4'h0
`define PTM_GRP_CNT    4'h1
`define PTM_GRP_PER    4'h2
`define PTM_ADDR_STAT  8'h30
`define PTM_ADDR_CLR   8'h34
`define PTM_ADDR_IEN   8'h38
`define PTM_B_EN       15
`define PTM_B_IDLE     13
`define PTM_B_GATE     6
`define PTM_B_PS_HI    5
`define PTM_B_PS_LO    4
`define PTM_B_PAIR     3
`define PTM_B_SRC      1
`define PTM_PER_RST    16'hFFFF
`define PTM_PS_LIM0    8'h00
`define PTM_PS_LIM1    8'h07
`define PTM_PS_LIM2    8'h3F
`define PTM_PS_LIM3    8'hFF
`endif

//--- ptm_pkg.sv
package ptm_pkg;
   typedef struct packed {
      logic       en;
      logic       idle_stop;
      logic       gate_en;
      logic [1:0] ps;
      logic       pair32;
      logic       ext_src;
   } ptm_ctrl_s;

   typedef struct packed {
      logic [7:0] pre;
   } ptm_tick_s;

   typedef struct packed {
      logic [3:0]        clk_s1;
      logic [3:0]        clk_s2;
      logic [3:0]        clk_s3;
      logic [3:0]        gate_s1;
      logic [3:0]        gate_s2;
      logic [3:0]        gate_s3;
      ptm_ctrl_s [3:0]   ctrl;
      logic [3:0][15:0]  cnt;
      logic [3:0][15:0]  per;
      logic [7:0]        status;
      logic [7:0]        enable;
      logic [31:0]       rdata;
      logic              irq;
      logic [3:0]        dma;
      logic              adc;
   } ptm_state_s;
endpackage

//--- ptm_tick.sv
`include "ptm_defines.svh"
module ptm_tick
   import ptm_pkg::*;
(
   input  wire logic      clk_in,
   input  wire logic      reset_in,
   input  wire logic      ce_in,
   input  wire logic      run_in,
   input  wire ptm_ctrl_s cfg_in,
   input  wire logic      ext_edge_in,
   input  wire logic      gate_lvl_in,
   output logic           tick_out
);
   ptm_tick_s  st_r;
   ptm_tick_s  st_nxt;
   logic       src;
   logic [7:0] lim;

   always_comb begin
      unique case (cfg_in.ps)
         2'h0: lim = `PTM_PS_LIM0;
         2'h1: lim = `PTM_PS_LIM1;
         2'h2: lim = `PTM_PS_LIM2;
         2'h3: lim = `PTM_PS_LIM3;
      endcase
      // external pulse or internal clock, internal one optionally gated
      src = cfg_in.ext_src ? ext_edge_in : (cfg_in.gate_en ? gate_lvl_in : 1'b1); // RULE8 RULE4
      tick_out = run_in && src && (st_r.pre >= lim); // RULE4
      st_nxt = st_r;
      if (!run_in) begin
         st_nxt.pre = 8'h00;
      end else if (src) begin
         st_nxt.pre = tick_out ? 8'h00 : st_r.pre + 8'h01;
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         st_r <= '0;
      end else if (ce_in) begin
         st_r <= st_nxt;
      end
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);

   gate_blocks_tick_a: assert property ( // RULE4
      (cfg_in.gate_en && !cfg_in.ext_src && !gate_lvl_in) |-> !tick_out)
      else $error("tick while gate low");
   prescale_step_a: assert property ( // RULE4
      (ce_in && run_in && src && !tick_out) |=> st_r.pre == $past(st_r.pre) + 8'h01)
      else $error("prescaler did not advance");
endmodule // ptm_tick

//--- ptm_paired_timer.sv
`include "ptm_defines.svh"
module ptm_paired_timer
   import ptm_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        reset_in,
   input  wire logic        ce_in,
   input  wire logic        idle_in,
   input  wire logic [7:0]  addr_in,
   input  wire logic [31:0] wdata_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   input  wire logic [3:0]  ext_clk_in,
   input  wire logic [3:0]  gate_pin_in,
   output logic [31:0]      rdata_out,
   output logic             irq_out,
   output logic [3:0]       dma_req_out,
   output logic             adc_trig_out,
   output logic [15:0]      tb_a_low_out,
   output logic [15:0]      tb_a_high_out
);
   ptm_state_s  st_r;
   ptm_state_s  st_nxt;
   logic [3:0]  tick_w;
   logic [3:0]  run_w;
   logic [3:0]  ext_edge_w;
   logic [3:0]  gate_fall_w;
   logic [3:0]  ev_match;
   logic [3:0]  ev_gate;
   logic [3:0]  grp_w;
   logic [1:0]  idx_w;
   logic        word_w;
   logic        cnt_wr_w;

   function automatic logic [15:0] ctrl_pack(input ptm_ctrl_s c);
      logic [15:0] v;
      v = 16'h0000;
      v[`PTM_B_EN] = c.en;
      v[`PTM_B_IDLE] = c.idle_stop;
      v[`PTM_B_GATE] = c.gate_en;
      v[`PTM_B_PS_HI:`PTM_B_PS_LO] = c.ps;
      v[`PTM_B_PAIR] = c.pair32;
      v[`PTM_B_SRC] = c.ext_src;
      return v;
   endfunction

   function automatic ptm_ctrl_s ctrl_unpack(input logic [15:0] v);
      ptm_ctrl_s c;
      c.en = v[`PTM_B_EN];
      c.idle_stop = v[`PTM_B_IDLE];
      c.gate_en = v[`PTM_B_GATE];
      c.ps = v[`PTM_B_PS_HI:`PTM_B_PS_LO];
      c.pair32 = v[`PTM_B_PAIR];
      c.ext_src = v[`PTM_B_SRC];
      return c;
   endfunction

   // pin edges read only the second and third sync stages
   assign ext_edge_w = st_r.clk_s2 & ~st_r.clk_s3;
   assign gate_fall_w = ~st_r.gate_s2 & st_r.gate_s3;
   assign grp_w = addr_in[7:4];
   assign idx_w = addr_in[3:2];
   assign word_w = (addr_in[1:0] == 2'h0);
   assign cnt_wr_w = wr_in && word_w && (grp_w == `PTM_GRP_CNT);

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_tick
         assign run_w[gi] = st_r.ctrl[gi].en && !(idle_in && st_r.ctrl[gi].idle_stop); // RULE4
         ptm_tick u_tick (
            .clk_in      (clk_in),
            .reset_in    (reset_in),
            .ce_in       (ce_in),
            .run_in      (run_w[gi]),
            .cfg_in      (st_r.ctrl[gi]),
            .ext_edge_in (ext_edge_w[gi]),
            .gate_lvl_in (st_r.gate_s2[gi]),
            .tick_out    (tick_w[gi])
         );
      end
   endgenerate

   always_comb begin
      logic        j32;
      logic [31:0] c32;
      logic [31:0] p32;
      int          lo;
      j32 = 1'b0;
      c32 = 32'h0000_0000;
      p32 = 32'h0000_0000;
      lo = 0;
      st_nxt = st_r;
      ev_match = 4'h0;
      ev_gate = 4'h0;
      // two-stage synchronisers, third stage for edges
      st_nxt.clk_s1 = ext_clk_in; // RULE3
      st_nxt.clk_s2 = st_r.clk_s1;
      st_nxt.clk_s3 = st_r.clk_s2;
      st_nxt.gate_s1 = gate_pin_in;
      st_nxt.gate_s2 = st_r.gate_s1;
      st_nxt.gate_s3 = st_r.gate_s2;

      for (int q = 0; q < 4; q++) begin
         lo = q - (q % 2);
         j32 = st_r.ctrl[lo].pair32; // RULE2 RULE1
         if (!j32) begin
            if (tick_w[q]) begin
               if (st_r.cnt[q] == st_r.per[q]) begin
                  st_nxt.cnt[q] = 16'h0000; // RULE15
                  ev_match[q] = 1'b1;
               end else begin
                  st_nxt.cnt[q] = st_r.cnt[q] + 16'h0001;
               end
            end
            ev_gate[q] = gate_fall_w[q] && run_w[q] && st_r.ctrl[q].gate_en
                         && !st_r.ctrl[q].ext_src;
         end else if (q % 2 == 1) begin
            // pair runs from the low timer tick, config and gate only
            c32 = {st_r.cnt[q], st_r.cnt[lo]}; // RULE9
            p32 = {st_r.per[q], st_r.per[lo]};
            if (tick_w[lo]) begin // RULE10 RULE11
               if (c32 == p32) begin
                  c32 = 32'h0000_0000; // RULE15
                  ev_match[q] = 1'b1; // RULE5 RULE12
               end else begin
                  c32 = c32 + 32'h0000_0001;
               end
            end
            st_nxt.cnt[q] = c32[31:16]; // RULE9
            st_nxt.cnt[lo] = c32[15:0];
            ev_gate[q] = gate_fall_w[lo] && run_w[lo] && st_r.ctrl[lo].gate_en
                         && !st_r.ctrl[lo].ext_src; // RULE11
         end
      end

      // bus writes override counting in the same cycle
      st_nxt.status = st_r.status | {ev_gate, ev_match};
      if (wr_in && word_w) begin
         unique case (grp_w)
            `PTM_GRP_CTRL: st_nxt.ctrl[idx_w] = ctrl_unpack(wdata_in[15:0]); // RULE14
            `PTM_GRP_CNT:  st_nxt.cnt[idx_w] = wdata_in[15:0];
            `PTM_GRP_PER:  st_nxt.per[idx_w] = wdata_in[15:0];
            default: begin
               if (addr_in == `PTM_ADDR_CLR) begin
                  // a new event in the clear cycle survives
                  st_nxt.status = (st_r.status & ~wdata_in[7:0]) | {ev_gate, ev_match};
               end
               if (addr_in == `PTM_ADDR_IEN) begin
                  st_nxt.enable = wdata_in[7:0];
               end
            end
         endcase
      end

      st_nxt.dma = ev_match; // RULE13
      st_nxt.adc = ev_match[1] | ev_match[3]; // RULE7
      st_nxt.irq = |(st_nxt.status & st_nxt.enable); // RULE5

      st_nxt.rdata = 32'h0000_0000;
      if (rd_in && word_w) begin
         unique case (grp_w)
            `PTM_GRP_CTRL: st_nxt.rdata = {16'h0000, ctrl_pack(st_r.ctrl[idx_w])};
            `PTM_GRP_CNT:  st_nxt.rdata = {16'h0000, st_r.cnt[idx_w]};
            `PTM_GRP_PER:  st_nxt.rdata = {16'h0000, st_r.per[idx_w]};
            default: begin
               if (addr_in == `PTM_ADDR_STAT) begin
                  st_nxt.rdata = {24'h00_0000, st_r.status};
               end
               if (addr_in == `PTM_ADDR_IEN) begin
                  st_nxt.rdata = {24'h00_0000, st_r.enable};
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         st_r <= '0;
         st_r.per <= {4{`PTM_PER_RST}};
      end else if (ce_in) begin
         st_r <= st_nxt;
      end
   end

   assign rdata_out = st_r.rdata;
   assign irq_out = st_r.irq;
   assign dma_req_out = st_r.dma;
   assign adc_trig_out = st_r.adc;
   assign tb_a_low_out = st_r.cnt[0]; // RULE6
   assign tb_a_high_out = st_r.cnt[1]; // RULE6

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);

   wrap_16bit_a: assert property ( // RULE15
      (ce_in && !st_r.ctrl[0].pair32 && tick_w[0] && st_r.cnt[0] == st_r.per[0]
       && !cnt_wr_w) |=> st_r.cnt[0] == 16'h0000)
      else $error("16-bit count did not wrap on match");
   count_16bit_a: assert property ( // RULE1
      (ce_in && !st_r.ctrl[0].pair32 && tick_w[1] && st_r.cnt[1] != st_r.per[1]
       && !cnt_wr_w) |=> st_r.cnt[1] == $past(st_r.cnt[1]) + 16'h0001)
      else $error("independent high timer did not count");
   carry_32bit_a: assert property ( // RULE9
      (ce_in && st_r.ctrl[0].pair32 && tick_w[0] && st_r.cnt[0] == 16'hFFFF
       && {st_r.cnt[1], st_r.cnt[0]} != {st_r.per[1], st_r.per[0]} && !cnt_wr_w)
      |=> st_r.cnt[0] == 16'h0000 && st_r.cnt[1] == $past(st_r.cnt[1]) + 16'h0001)
      else $error("low word carry not passed to high word");
   hold_32bit_a: assert property ( // RULE11
      (ce_in && st_r.ctrl[0].pair32 && !tick_w[0] && !cnt_wr_w)
      |=> $stable(st_r.cnt[1]) && $stable(st_r.cnt[0]))
      else $error("pair moved without low timer tick");
   flag_32bit_a: assert property ( // RULE12
      (ce_in && st_r.ctrl[0].pair32 && tick_w[0] && !cnt_wr_w
       && {st_r.cnt[1], st_r.cnt[0]} == {st_r.per[1], st_r.per[0]})
      |=> st_r.status[1] && dma_req_out[1] && !dma_req_out[0] && adc_trig_out)
      else $error("32-bit match not flagged on high timer");
   irq_level_a: assert property ( // RULE5
      irq_out == |(st_r.status & st_r.enable))
      else $error("interrupt level disagrees with status");
   adc_low_a: assert property ( // RULE7
      (ce_in && (ev_match[0] | ev_match[2]) && !(ev_match[1] | ev_match[3]))
      |=> !adc_trig_out)
      else $error("low timer raised converter trigger");
   dma_pulse_a: assert property ( // RULE13
      (ce_in && ev_match[2]) |=> dma_req_out[2])
      else $error("match did not request dma");
   idle_stop_a: assert property ( // RULE4
      (idle_in && st_r.ctrl[2].idle_stop) |-> !tick_w[2])
      else $error("timer ticked while stopped in idle");

   status_sticky_a: assert property ( // RULE5
      (ce_in && !(wr_in && addr_in == `PTM_ADDR_CLR))
      |=> (st_r.status & $past(st_r.status)) == $past(st_r.status))
      else $error("status bit dropped without clear");
   match_sets_status_a: assert property ( // RULE5
      (ce_in && ev_match != 4'h0)
      |=> (st_r.status[3:0] & $past(ev_match)) == $past(ev_match))
      else $error("match event lost from status");
   gate_sets_status_a: assert property ( // RULE4
      (ce_in && ev_gate != 4'h0)
      |=> (st_r.status[7:4] & $past(ev_gate)) == $past(ev_gate))
      else $error("gate event lost from status");
   clear_status_a: assert property ( // RULE5
      (ce_in && wr_in && addr_in == `PTM_ADDR_CLR && ev_match == 4'h0 && ev_gate == 4'h0)
      |=> ({24'h00_0000, st_r.status} & $past(wdata_in)) == 32'h0000_0000)
      else $error("status clear did not take");
   enable_write_a: assert property ( // RULE5
      (ce_in && wr_in && addr_in == `PTM_ADDR_IEN)
      |=> st_r.enable == $past(wdata_in[7:0]))
      else $error("enable write did not land");
   read_status_a: assert property ( // RULE5
      (ce_in && rd_in && addr_in == `PTM_ADDR_STAT)
      |=> rdata_out == {24'h00_0000, $past(st_r.status)})
      else $error("status read returned wrong data");

   rdata_quiet_a: assert property ( // RULE14
      (ce_in && !rd_in) |=> rdata_out == 32'h0000_0000)
      else $error("read data stood without a read");
   read_period_a: assert property ( // RULE14
      (ce_in && rd_in && addr_in == 8'h20)
      |=> rdata_out == {16'h0000, $past(st_r.per[0])})
      else $error("period read returned wrong data");
   unmapped_read_a: assert property ( // RULE14
      (ce_in && rd_in && addr_in == 8'h3C) |=> rdata_out == 32'h0000_0000)
      else $error("unmapped read returned data");
   ctrl_write_a: assert property ( // RULE14
      (ce_in && wr_in && addr_in == 8'h00)
      |=> st_r.ctrl[0].en == $past(wdata_in[`PTM_B_EN]))
      else $error("control write did not land");
   per_write_a: assert property ( // RULE14
      (ce_in && wr_in && addr_in == 8'h24)
      |=> st_r.per[1] == $past(wdata_in[15:0]))
      else $error("period write did not land");
   cnt_write_a: assert property ( // RULE14
      (ce_in && wr_in && addr_in == 8'h18)
      |=> st_r.cnt[2] == $past(wdata_in[15:0]))
      else $error("count write lost against a tick");
   unaligned_write_a: assert property ( // RULE14
      (ce_in && wr_in && addr_in[1:0] != 2'h0)
      |=> $stable(st_r.ctrl) && $stable(st_r.per) && $stable(st_r.enable))
      else $error("unaligned write changed a register");
   disabled_stop_a: assert property ( // RULE14
      !st_r.ctrl[0].en |-> !tick_w[0])
      else $error("disabled timer ticked");

   ce_freeze_a: assert property ( // RULE4
      !ce_in |=> $stable(st_r.cnt) && $stable(rdata_out) && $stable(irq_out))
      else $error("state moved while clock enable low");
   idle_run_a: assert property ( // RULE4
      (st_r.ctrl[0].en && !st_r.ctrl[0].idle_stop && !st_r.ctrl[0].gate_en
       && !st_r.ctrl[0].ext_src && st_r.ctrl[0].ps == 2'h0) |-> tick_w[0])
      else $error("undivided timer missed a tick");
   hold_16bit_a: assert property ( // RULE8
      (ce_in && !st_r.ctrl[0].pair32 && !tick_w[0] && !cnt_wr_w)
      |=> $stable(st_r.cnt[0]))
      else $error("timer moved without a tick");
   ext_synced_a: assert property ( // RULE3
      (st_r.ctrl[3].ext_src && !st_r.ctrl[2].pair32 && tick_w[3]) |-> ext_edge_w[3])
      else $error("external tick without synchronised edge");
   count_high_b_a: assert property ( // RULE1
      (ce_in && !st_r.ctrl[2].pair32 && tick_w[3] && st_r.cnt[3] != st_r.per[3]
       && !cnt_wr_w) |=> st_r.cnt[3] == $past(st_r.cnt[3]) + 16'h0001)
      else $error("independent timer did not count");

   dma_match_only_a: assert property ( // RULE13
      (ce_in && ev_match == 4'h0) |=> dma_req_out == 4'h0)
      else $error("dma request without match");
   adc_high_b_a: assert property ( // RULE7
      (ce_in && ev_match[3]) |=> adc_trig_out)
      else $error("high timer match gave no converter trigger");
   pair_a_flags_a: assert property ( // RULE12
      st_r.ctrl[0].pair32 |-> !ev_match[0] && !ev_gate[0])
      else $error("joined pair a flagged on low timer");
   pair_b_flags_a: assert property ( // RULE12
      st_r.ctrl[2].pair32 |-> !ev_match[2] && !ev_gate[2])
      else $error("joined pair b flagged on low timer");
   wrap_32bit_b_a: assert property ( // RULE15
      (ce_in && st_r.ctrl[2].pair32 && tick_w[2] && !cnt_wr_w
       && {st_r.cnt[3], st_r.cnt[2]} == {st_r.per[3], st_r.per[2]})
      |=> st_r.cnt[3] == 16'h0000 && st_r.cnt[2] == 16'h0000 && st_r.status[3]
          && dma_req_out[3] && !dma_req_out[2])
      else $error("joined pair b did not wrap and flag");

   wrap_16bit_c: cover property (ce_in && !st_r.ctrl[0].pair32 && ev_match[0]);
   match_32bit_c: cover property (ce_in && st_r.ctrl[2].pair32 && ev_match[3]);
   gate_event_c: cover property (ce_in && ev_gate != 4'h0);
   ext_count_c: cover property (ce_in && st_r.ctrl[2].pair32 && st_r.ctrl[2].ext_src && tick_w[2]);
   irq_rise_c: cover property (!irq_out ##1 irq_out);
endmodule // ptm_paired_timer

//--- tb.sv
`include "ptm_defines.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] EN  = 32'h0000_0001 << `PTM_B_EN;
   localparam logic [31:0] IDL = 32'h0000_0001 << `PTM_B_IDLE;
   localparam logic [31:0] GT  = 32'h0000_0001 << `PTM_B_GATE;
   localparam logic [31:0] PR  = 32'h0000_0001 << `PTM_B_PAIR;
   localparam logic [31:0] SRC = 32'h0000_0001 << `PTM_B_SRC;
   localparam logic [31:0] PS  = 32'h0000_0003 << `PTM_B_PS_LO;
   localparam logic [3:0]  CT  = `PTM_GRP_CTRL;
   localparam logic [3:0]  CN  = `PTM_GRP_CNT;
   localparam logic [3:0]  PE  = `PTM_GRP_PER;
   logic        clk_in = 1'b0;
   logic        reset_in = 1'b1;
   logic        ce_in = 1'b1;
   logic        idle_in = 1'b0;
   logic        wr_in = 1'b0;
   logic        rd_in = 1'b0;
   logic        rd_d = 1'b0;
   logic        hit;
   logic [7:0]  addr_in = 8'h00;
   logic [31:0] wdata_in = 32'h0000_0000;
   logic [3:0]  ext_clk_in = 4'h0;
   logic [3:0]  gate_pin_in = 4'h0;
   logic [31:0] rdata_out;
   logic        irq_out;
   logic [3:0]  dma_req_out;
   logic        adc_trig_out;
   logic [15:0] tb_a_low_out;
   logic [15:0] tb_a_high_out;
   logic [15:0] v;
   logic [31:0] r;
   logic [31:0] exp_q[$];
   int          fails;
   int          checked;
   int          cyc;
   int          ac;
   int          n;
   int          dc[4];
   int          s[5];
   int          divs[4] = '{1, 8, 64, 256};
   integer      seed = 32'h0000_01E4;

   ptm_paired_timer ptm_paired_timer_inst (
      .clk_in,
      .reset_in,
      .ce_in,
      .idle_in,
      .addr_in,
      .wdata_in,
      .wr_in,
      .rd_in,
      .ext_clk_in,
      .gate_pin_in,
      .rdata_out,
      .irq_out,
      .dma_req_out,
      .adc_trig_out,
      .tb_a_low_out,
      .tb_a_high_out
   );

   always #2.5 clk_in = ~clk_in;

   function automatic logic [7:0] ra(input logic [3:0] g, input int t);
      ra = {g, t[1:0], 2'b00};
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic close_out();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge clk_in);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      exp_q.push_back(e);
      @(posedge clk_in);
      rd_in <= 1'b0;
   endtask

   task automatic snap();
      for (int i = 0; i < 4; i++) begin
         s[i] = dc[i];
      end
      s[4] = ac;
   endtask

   // read data and pulse counts, plus the hang limit
   always @(posedge clk_in) begin
      rd_d <= rd_in;
      cyc <= cyc + 1;
      ac <= ac + int'(adc_trig_out);
      for (int i = 0; i < 4; i++) begin
         dc[i] <= dc[i] + int'(dma_req_out[i]);
      end
      if (rd_d) check(rdata_out, exp_q.pop_front());
      if (cyc == 20000) begin
         fails++;
         close_out();
      end
   end

   initial begin
      repeat (10) @(posedge clk_in);
      reset_in <= 1'b0;
      for (int t = 0; t < 4; t++) begin
         rd(ra(CT, t), 32'h0000_0000);
         rd(ra(PE, t), {16'h0000, `PTM_PER_RST});
         r = $random(seed);
         wr(ra(PE, t), r);
         rd(ra(PE, t), {16'h0000, r[15:0]});
      end
      rd(8'h3C, 32'h0000_0000);
      wr(ra(CT, 2), 32'hFFFF_FFFF);
      rd(ra(CT, 2), EN | IDL | GT | PS | PR | SRC);
      wr(ra(CT, 2), 32'h0000_0000);
      wr(`PTM_ADDR_STAT, 32'h0000_00FF);
      rd(`PTM_ADDR_STAT, 32'h0000_0000);
      // joined pair a, high control asks for a gate that stays shut
      wr(ra(CT, 1), EN | GT);
      wr(ra(PE, 0), 32'h0000_0002);
      wr(ra(PE, 1), 32'h0000_0001);
      wr(ra(CN, 0), 32'h0000_FFF0);
      wr(ra(CN, 1), 32'h0000_0000);
      snap();
      wr(ra(CT, 0), EN | PR);
      hit = 1'b0;
      n = 0;
      while (dma_req_out[1] !== 1'b1 && n < 40) begin
         @(posedge clk_in);
         n++;
         if ({tb_a_high_out, tb_a_low_out} === 32'h0001_0002) hit = 1'b1;
      end
      check(n < 40, 1'b1);
      check(hit, 1'b1);
      tick(3);
      check(tb_a_high_out, 16'h0000);
      check(tb_a_low_out < 16'h0005, 1'b1);
      wr(ra(CT, 0), 32'h0000_0000);
      check(dc[0] - s[0], 0);
      check(dc[1] - s[1], 1);
      check(ac - s[4], 1);
      rd(`PTM_ADDR_STAT, 32'h0000_0002);
      wr(`PTM_ADDR_CLR, 32'h0000_00FF);
      // two separate 16-bit timers of pair a
      wr(ra(PE, 0), 32'h0000_0004);
      wr(ra(PE, 1), 32'h0000_0006);
      wr(ra(CN, 0), 32'h0000_0000);
      wr(ra(CT, 1), EN);
      wr(ra(CT, 0), EN);
      tick(20);
      snap();
      tick(70);
      check(dc[0] - s[0], 14);
      check(dc[1] - s[1], 10);
      check(ac - s[4], 10);
      check(irq_out, 1'b0);
      rd(`PTM_ADDR_STAT, 32'h0000_0003);
      wr(`PTM_ADDR_IEN, 32'h0000_0002);
      tick(2);
      check(irq_out, 1'b1);
      rd(`PTM_ADDR_IEN, 32'h0000_0002);
      wr(ra(CT, 0), 32'h0000_0000);
      wr(ra(CT, 1), 32'h0000_0000);
      wr(`PTM_ADDR_CLR, 32'h0000_00FF);
      tick(2);
      check(irq_out, 1'b0);
      rd(`PTM_ADDR_STAT, 32'h0000_0000);
      // every prescale code on timer 2
      wr(ra(PE, 2), 32'h0000_0000);
      for (int p = 0; p < 4; p++) begin
         wr(ra(CT, 2), EN | (p << `PTM_B_PS_LO));
         tick(2 * divs[p] + 2);
         snap();
         tick(4 * divs[p]);
         check(dc[2] - s[2], 4);
      end
      wr(ra(CT, 2), 32'h0000_0000);
      // external pulses on timer 3
      wr(ra(PE, 3), 32'h0000_0004);
      wr(ra(CN, 3), 32'h0000_0000);
      snap();
      wr(ra(CT, 3), EN | SRC);
      repeat (5) begin
         ext_clk_in[3] <= 1'b1;
         tick(3);
         ext_clk_in[3] <= 1'b0;
         tick(3);
      end
      tick(6);
      check(dc[3] - s[3], 1);
      check(ac - s[4], 1);
      wr(ra(CT, 3), 32'h0000_0000);
      // pair b as 32-bit counter, only the low timer pin counts
      wr(ra(PE, 2), 32'h0000_0001);
      wr(ra(PE, 3), 32'h0000_0000);
      wr(ra(CN, 2), 32'h0000_0000);
      wr(ra(CN, 3), 32'h0000_0000);
      wr(8'h09, 32'hFFFF_FFFF);
      rd(ra(CT, 2), 32'h0000_0000);
      snap();
      wr(ra(CT, 2), EN | PR | SRC);
      for (int k = 0; k < 5; k++) begin
         ext_clk_in <= (k < 3) ? 4'h8 : 4'h4;
         tick(3);
         ext_clk_in <= 4'h0;
         tick(3);
      end
      tick(6);
      check(dc[2] - s[2], 0);
      check(dc[3] - s[3], 1);
      check(ac - s[4], 1);
      wr(ra(CT, 2), 32'h0000_0000);
      // gated counting on timer 0
      wr(ra(CN, 0), 32'h0000_0000);
      wr(ra(PE, 0), 32'h0000_FFFF);
      wr(`PTM_ADDR_CLR, 32'h0000_00FF);
      wr(ra(CT, 0), EN | GT);
      tick(6);
      v = tb_a_low_out;
      tick(5);
      check(tb_a_low_out, v);
      gate_pin_in[0] <= 1'b1;
      tick(10);
      check(tb_a_low_out != v, 1'b1);
      gate_pin_in[0] <= 1'b0;
      tick(8);
      rd(`PTM_ADDR_STAT, 32'h0000_0010);
      // idle with and without the stop bit, then clock enable low
      wr(ra(CT, 0), EN | IDL);
      idle_in <= 1'b1;
      tick(3);
      v = tb_a_low_out;
      tick(5);
      check(tb_a_low_out, v);
      wr(ra(CT, 0), EN);
      tick(2);
      v = tb_a_low_out;
      tick(5);
      check(tb_a_low_out - v, 32'h0000_0005);
      idle_in <= 1'b0;
      ce_in <= 1'b0;
      tick(2);
      v = tb_a_low_out;
      tick(4);
      check(tb_a_low_out, v);
      ce_in <= 1'b1;
      tick(3);
      close_out();
   end
endmodule // tb
